// ==== pkg/rtc_ccr_pkg.sv ====
// constants and types for the clock/control register space
package rtc_ccr_pkg;

	// ----------------------------------------
	// serial bus framing
	// ----------------------------------------
	localparam logic [6:0] DEV_CODE     = 7'h6f;
	localparam logic [7:0] ADDR_HI_OK   = 8'h00;
	localparam logic [7:0] ADDR_MAX     = 8'h3f;

	// ----------------------------------------
	// sections, by address bits [5:3]
	// ----------------------------------------
	localparam logic [2:0] SEC_ALARM0   = 3'h0;
	localparam logic [2:0] SEC_ALARM1   = 3'h1;
	localparam logic [2:0] SEC_CTRL     = 3'h2;
	localparam logic [2:0] SEC_CLOCK    = 3'h6;
	localparam logic [5:0] STATUS_ADDR  = 6'h3f;
	localparam logic [5:0] CTRL_BASE    = 6'h10;
	localparam logic [5:0] CTRL_LAST    = 6'h14;
	localparam logic [2:0] CTRL_LEN     = 3'h5;
	localparam logic [4:0] NV_CTRL_OFS  = 5'h10;
	localparam int         NV_BYTES     = 21;

	// ----------------------------------------
	// clock byte indices and fields
	// ----------------------------------------
	localparam logic [2:0] CK_SEC       = 3'h0;
	localparam logic [2:0] CK_MIN       = 3'h1;
	localparam logic [2:0] CK_HOUR      = 3'h2;
	localparam logic [2:0] CK_DATE      = 3'h3;
	localparam logic [2:0] CK_MONTH     = 3'h4;
	localparam logic [2:0] CK_YEAR      = 3'h5;
	localparam logic [2:0] CK_WDAY      = 3'h6;
	localparam logic [2:0] CK_CENT      = 3'h7;
	localparam int         HR_MIL_BIT   = 7;
	localparam int         HR_PM_BIT    = 5;
	localparam logic [63:0] CLK_RESET   = 64'h2000_0001_0000_0000;
	localparam logic [7:0] CENT_19      = 8'h19;
	localparam logic [7:0] CENT_20      = 8'h20;
	localparam logic [7:0] WDAY_LAST    = 8'h06;

	// ----------------------------------------
	// status byte layout and latch commands
	// ----------------------------------------
	localparam int         SR_BAT       = 7;
	localparam int         SR_AL1       = 6;
	localparam int         SR_AL0       = 5;
	localparam int         SR_OSCILLATOR_STOPPED_FLAG      = 4;
	localparam int         SR_REGISTER_WRITE_LATCH      = 2;
	localparam int         SR_WEL       = 1;
	localparam int         SR_TOTAL_POWER_LOSS_FLAG      = 0;
	localparam logic [7:0] SR_RESET     = 8'h01;
	localparam logic [7:0] CMD_WL_SET   = 8'h02;
	localparam logic [7:0] CMD_BOTH_SET = 8'h06;
	localparam logic [7:0] CMD_CLEAR    = 8'h00;

	// ----------------------------------------
	// timing counts (crystal cycles, ref cycles)
	// ----------------------------------------
	localparam logic [15:0] XTAL_PER_SEC = 16'h8000;
	localparam logic [15:0] OSC_TIMEOUT  = 16'h4000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_ACK  = 3'b010,
		ST_TX   = 3'b011,
		ST_RACK = 3'b100
	} bus_state_t;

	typedef enum logic [1:0] {
		PH_DEV  = 2'b00,
		PH_AHI  = 2'b01,
		PH_ALO  = 2'b10,
		PH_DATA = 2'b11
	} phase_t;

endpackage

// ==== src/crystal_second_divider.sv ====
// crystal domain: one-second toggle and oscillator activity toggle
`timescale 1ns/1ps
module crystal_second_divider #(
	parameter logic [15:0] XTAL_DIV = rtc_ccr_pkg::XTAL_PER_SEC
) (
	// crystal clock and reset from the core domain
	input  wire logic i_xtal_clk,
	input  wire logic i_rstn,
	// toggles read across the domain boundary
	output logic      o_alive_tgl,
	output logic      o_second_tgl
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [1:0]  rst_sy;
		logic [15:0] cnt;
		logic        alive;
		logic        sec;
	} div_state_t;

	div_state_t q;
	div_state_t n;

	always_comb begin
		n = q;
		n.rst_sy = {q.rst_sy[0], i_rstn};
		n.alive = ~q.alive;
		if (q.cnt == XTAL_DIV - 16'h1) begin
			n.cnt = 16'h0;
			n.sec = ~q.sec;
		end else begin
			n.cnt = q.cnt + 16'h1;
		end
		if (!q.rst_sy[1]) begin
			n.cnt = 16'h0;
			n.alive = 1'b0;
			n.sec = 1'b0;
		end
	end

	always_ff @(posedge i_xtal_clk) begin
		q <= n;
	end

	assign o_alive_tgl = q.alive;
	assign o_second_tgl = q.sec;

endmodule // crystal_second_divider

// ==== src/rtc_clock_control_space.sv ====
// serial-bus clock/control register space with time counters and status byte
`timescale 1ns/1ps
// Summary of operation
// - answer only slave code 1101111x and addresses 0000h..003Fh, apart from array
// - writes buffered; counters and stored bytes update on valid stop with latch set
// - sequential access stays inside one section; any start address allowed
// - status byte is single byte only; continuing terminates the operation
// - read command snapshots all clock bytes; reads never return array data
// - after a read the pointer rests at last address plus one
// - time bytes are BCD: sec/min 00-59, date 1-31, month 1-12, year 0-99
// - weekday is three bits, counts 0..6 then wraps, defaults 0
// - century holds only 19 or 20 in BCD
// - 24-hour bit set: 0-23; clear: 1-12 with PM flag; default 12-hour, AM
// - February gets 29 days when year is divisible by 4
// - status byte at 003Fh with fixed bit layout, only power-loss defaults 1
// - battery flag reads 1 while running from backup supply only
// - alarm flags set on match; status read clears only flags set at its start
// - oscillator flag set while oscillator stopped, cleared while it runs
// - both write latches power up clear and need no programming cycle
// - with write latch clear, writes to all but the status byte are dropped, their bytes still acknowledged
// - power-loss flag set after both supplies lost, cleared by first clock write
// - time update as one page write, committed on valid stop, dropped otherwise
// - counters stay stopped after total power loss until a clock write
// - clock bytes captured at the acknowledge before data out; clock keeps running
module rtc_clock_control_space #(
	parameter logic [15:0] XTAL_DIV    = rtc_ccr_pkg::XTAL_PER_SEC,
	parameter logic [15:0] OSC_TIMEOUT = rtc_ccr_pkg::OSC_TIMEOUT
) (
	// core clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rstn,
	// crystal timebase
	input  wire logic i_xtal_clk,
	// serial bus pins
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_sda,
	output logic      o_sda_oe_n,
	// supplies and alarm comparators
	input  wire logic i_main_supply_ok,
	input  wire logic i_backup_supply_ok,
	input  wire logic i_alarm0_hit,
	input  wire logic i_alarm1_hit,
	// status
	output logic      o_clock_running
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [2:0]              scl_sy;
		logic [2:0]              sda_sy;
		logic [1:0]              main_sy;
		logic [1:0]              bak_sy;
		logic [2:0]              alive_sy;
		logic [2:0]              sec_sy;
		rtc_ccr_pkg::bus_state_t st;
		rtc_ccr_pkg::phase_t     phase;
		logic                    rw;
		logic                    full;
		logic                    more;
		logic                    drv_low;
		logic                    snap_pend;
		logic [7:0]              shreg;
		logic [2:0]              bitcnt;
		logic [5:0]              ptr;
		logic [2:0]              wsec;
		logic                    wstat;
		logic                    wgot;
		logic [7:0]              wmask;
		logic [7:0][7:0]         wbuf;
		logic [7:0][7:0]         clk;
		logic [7:0][7:0]         hold;
		logic [20:0][7:0]        nv;
		logic                    write_latch_primary;
		logic                    register_write_latch;
		logic                    on_backup_supply_flag;
		logic                    al1;
		logic                    al0;
		logic                    oscillator_stopped_flag;
		logic                    total_power_loss_flag;
		logic                    run;
		logic                    st_rd;
		logic [1:0]              al_snap;
		logic [15:0]             osc_cnt;
	} core_state_t;

	core_state_t q;
	core_state_t n;
	logic        alive_tgl;
	logic        second_tgl;

	localparam int HR_MIL = rtc_ccr_pkg::HR_MIL_BIT;
	localparam int HR_PM = rtc_ccr_pkg::HR_PM_BIT;

	crystal_second_divider #(
		.XTAL_DIV (XTAL_DIV)
	) u_div (
		.i_xtal_clk   (i_xtal_clk),
		.i_rstn       (i_rstn),
		.o_alive_tgl  (alive_tgl),
		.o_second_tgl (second_tgl)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic logic [7:0] month_len(input logic [7:0] mo, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mo)
			8'h02: return leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	function automatic logic [5:0] next_ptr(input logic [5:0] p);
		if (p == rtc_ccr_pkg::STATUS_ADDR) begin
			return p;
		end else if (p == rtc_ccr_pkg::CTRL_LAST) begin
			return rtc_ccr_pkg::CTRL_BASE;
		end else begin
			return {p[5:3], p[2:0] + 3'h1};
		end
	endfunction

	// ----------------------------------------
	// combinational next state
	// ----------------------------------------
	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;
	logic       sec_tick;
	logic       commit_ok;
	logic       clk_commit;
	logic       al_clear;
	logic       defined;
	logic [7:0] rdat;
	logic [7:0] sr_byte;

	always_comb begin
		logic [7:0] h;
		logic       day_carry;
		h = 8'h0;
		day_carry = 1'b0;
		n = q;
		n.scl_sy = {q.scl_sy[1:0], i_scl};
		n.sda_sy = {q.sda_sy[1:0], i_sda};
		n.main_sy = {q.main_sy[0], i_main_supply_ok};
		n.bak_sy = {q.bak_sy[0], i_backup_supply_ok};
		n.alive_sy = {q.alive_sy[1:0], alive_tgl};
		n.sec_sy = {q.sec_sy[1:0], second_tgl};

		scl_rise = q.scl_sy[1] & ~q.scl_sy[2];
		scl_fall = ~q.scl_sy[1] & q.scl_sy[2];
		bus_start = q.scl_sy[1] & q.scl_sy[2] & q.sda_sy[2] & ~q.sda_sy[1];
		bus_stop = q.scl_sy[1] & q.scl_sy[2] & ~q.sda_sy[2] & q.sda_sy[1];
		sec_tick = q.sec_sy[1] ^ q.sec_sy[2];

		sr_byte = 8'h0;
		sr_byte[rtc_ccr_pkg::SR_BAT] = q.on_backup_supply_flag;
		sr_byte[rtc_ccr_pkg::SR_AL1] = q.al1;
		sr_byte[rtc_ccr_pkg::SR_AL0] = q.al0;
		sr_byte[rtc_ccr_pkg::SR_OSCILLATOR_STOPPED_FLAG] = q.oscillator_stopped_flag;
		sr_byte[rtc_ccr_pkg::SR_REGISTER_WRITE_LATCH] = q.register_write_latch;
		sr_byte[rtc_ccr_pkg::SR_WEL] = q.write_latch_primary;
		sr_byte[rtc_ccr_pkg::SR_TOTAL_POWER_LOSS_FLAG] = q.total_power_loss_flag;

		// read data: never from the array, undefined reads zero
		defined = 1'b1;
		case (q.ptr[5:3])
			rtc_ccr_pkg::SEC_ALARM0, rtc_ccr_pkg::SEC_ALARM1: rdat = q.nv[q.ptr[3:0]];
			rtc_ccr_pkg::SEC_CTRL: begin
				defined = q.ptr[2:0] < rtc_ccr_pkg::CTRL_LEN;
				rdat = defined ? q.nv[rtc_ccr_pkg::NV_CTRL_OFS + {2'b0, q.ptr[2:0]}] : 8'h0;
			end
			rtc_ccr_pkg::SEC_CLOCK: rdat = q.snap_pend ? q.clk[q.ptr[2:0]] : q.hold[q.ptr[2:0]];
			default: begin
				defined = q.ptr == rtc_ccr_pkg::STATUS_ADDR;
				rdat = defined ? sr_byte : 8'h0;
			end
		endcase

		// supplies and oscillator watch
		n.on_backup_supply_flag = ~q.main_sy[1] & q.bak_sy[1];
		if (~q.main_sy[1] & ~q.bak_sy[1]) begin
			n.total_power_loss_flag = 1'b1;
			n.run = 1'b0;
		end
		if (q.alive_sy[1] ^ q.alive_sy[2]) begin
			n.osc_cnt = 16'h0;
			n.oscillator_stopped_flag = 1'b0;
		end else if (q.osc_cnt >= OSC_TIMEOUT) begin
			n.oscillator_stopped_flag = 1'b1;
		end else begin
			n.osc_cnt = q.osc_cnt + 16'h1;
		end

		// time counting
		if (sec_tick && q.run) begin
			if (q.clk[0] == 8'h59) begin
				n.clk[0] = 8'h0;
				if (q.clk[1] == 8'h59) begin
					n.clk[1] = 8'h0;
					if (q.clk[2][HR_MIL]) begin
						if (q.clk[2][5:0] == 6'h23) begin
							n.clk[2][5:0] = 6'h0;
							day_carry = 1'b1;
						end else begin
							h = bcd_inc({2'b0, q.clk[2][5:0]});
							n.clk[2][5:0] = h[5:0];
						end
					end else if (q.clk[2][4:0] == 5'h12) begin
						n.clk[2][4:0] = 5'h01;
					end else if (q.clk[2][4:0] == 5'h11) begin
						n.clk[2][4:0] = 5'h12;
						n.clk[2][HR_PM] = ~q.clk[2][HR_PM];
						day_carry = q.clk[2][HR_PM];
					end else begin
						h = bcd_inc({3'b0, q.clk[2][4:0]});
						n.clk[2][4:0] = h[4:0];
					end
				end else begin
					n.clk[1] = bcd_inc(q.clk[1]);
				end
			end else begin
				n.clk[0] = bcd_inc(q.clk[0]);
			end
			if (day_carry) begin
				n.clk[6] = (q.clk[6] >= rtc_ccr_pkg::WDAY_LAST) ? 8'h0 : q.clk[6] + 8'h1;
				if (q.clk[3] >= month_len(q.clk[4], q.clk[5])) begin
					n.clk[3] = 8'h01;
					if (q.clk[4] == 8'h12) begin
						n.clk[4] = 8'h01;
						if (q.clk[5] == 8'h99) begin
							n.clk[5] = 8'h0;
							if (q.clk[7] == rtc_ccr_pkg::CENT_19) begin
								n.clk[7] = rtc_ccr_pkg::CENT_20;
							end
						end else begin
							n.clk[5] = bcd_inc(q.clk[5]);
						end
					end else begin
						n.clk[4] = bcd_inc(q.clk[4]);
					end
				end else begin
					n.clk[3] = bcd_inc(q.clk[3]);
				end
			end
		end

		// serial bus engine
		al_clear = 1'b0;
		commit_ok = 1'b0;
		clk_commit = 1'b0;
		if (bus_stop) begin
			// the stop's own scl rise is counted as one bit after the last ack
			commit_ok = q.st == rtc_ccr_pkg::ST_RX && q.bitcnt == 3'h1 && !q.rw
				&& q.phase == rtc_ccr_pkg::PH_DATA && q.wgot;
			n.st = rtc_ccr_pkg::ST_IDLE;
			n.drv_low = 1'b0;
			n.wgot = 1'b0;
			n.wmask = 8'h0;
		end else if (bus_start) begin
			n.st = rtc_ccr_pkg::ST_RX;
			n.phase = rtc_ccr_pkg::PH_DEV;
			n.bitcnt = 3'h0;
			n.full = 1'b0;
			n.drv_low = 1'b0;
			n.wgot = 1'b0;
			n.wmask = 8'h0;
		end else begin
			case (q.st)
				rtc_ccr_pkg::ST_RX: begin
					if (scl_rise) begin
						n.shreg = {q.shreg[6:0], q.sda_sy[1]};
						n.bitcnt = q.bitcnt + 3'h1;
						n.full = q.bitcnt == 3'h7;
					end else if (scl_fall && q.full) begin
						n.full = 1'b0;
						n.st = rtc_ccr_pkg::ST_ACK;
						n.drv_low = 1'b1;
						case (q.phase)
							rtc_ccr_pkg::PH_DEV: begin
								n.rw = q.shreg[0];
								n.phase = q.shreg[0] ? rtc_ccr_pkg::PH_DATA : rtc_ccr_pkg::PH_AHI;
								n.snap_pend = q.shreg[0];
								if (q.shreg[7:1] != rtc_ccr_pkg::DEV_CODE) begin
									n.st = rtc_ccr_pkg::ST_IDLE;
									n.drv_low = 1'b0;
								end
							end
							rtc_ccr_pkg::PH_AHI: begin
								n.phase = rtc_ccr_pkg::PH_ALO;
								if (q.shreg != rtc_ccr_pkg::ADDR_HI_OK) begin
									n.st = rtc_ccr_pkg::ST_IDLE;
									n.drv_low = 1'b0;
								end
							end
							rtc_ccr_pkg::PH_ALO: begin
								n.phase = rtc_ccr_pkg::PH_DATA;
								n.ptr = q.shreg[5:0];
								if (q.shreg > rtc_ccr_pkg::ADDR_MAX) begin
									n.st = rtc_ccr_pkg::ST_IDLE;
									n.drv_low = 1'b0;
								end
							end
							default: begin
								if (q.wgot && q.wstat) begin
									n.st = rtc_ccr_pkg::ST_IDLE;
									n.drv_low = 1'b0;
									n.wgot = 1'b0;
								end else begin
									n.wgot = 1'b1;
									if (!q.wgot) begin
										n.wsec = q.ptr[5:3];
										n.wstat = q.ptr == rtc_ccr_pkg::STATUS_ADDR;
									end
									n.wbuf[q.ptr[2:0]] = q.shreg;
									n.wmask[q.ptr[2:0]] = defined;
									n.ptr = next_ptr(q.ptr);
								end
							end
						endcase
					end
				end
				rtc_ccr_pkg::ST_ACK: begin
					if (scl_fall) begin
						n.bitcnt = 3'h0;
						n.drv_low = 1'b0;
						n.st = rtc_ccr_pkg::ST_RX;
						if (q.rw) begin
							n.st = rtc_ccr_pkg::ST_TX;
						end
						if (q.snap_pend) begin
							n.hold = q.clk;
							n.snap_pend = 1'b0;
						end
						if (q.rw) begin
							n.shreg = rdat;
							n.drv_low = ~rdat[7];
							n.st_rd = q.ptr == rtc_ccr_pkg::STATUS_ADDR;
							n.al_snap = {q.al1, q.al0};
						end
					end
				end
				rtc_ccr_pkg::ST_TX: begin
					if (scl_fall) begin
						n.bitcnt = q.bitcnt + 3'h1;
						n.shreg = {q.shreg[6:0], 1'b0};
						n.drv_low = ~q.shreg[6];
						if (q.bitcnt == 3'h7) begin
							n.drv_low = 1'b0;
							n.st = rtc_ccr_pkg::ST_RACK;
							n.ptr = next_ptr(q.ptr);
							al_clear = q.st_rd;
						end
					end
				end
				rtc_ccr_pkg::ST_RACK: begin
					if (scl_rise) begin
						n.more = ~q.sda_sy[1] & ~q.st_rd;
					end else if (scl_fall) begin
						n.st = q.more ? rtc_ccr_pkg::ST_TX : rtc_ccr_pkg::ST_IDLE;
						n.bitcnt = 3'h0;
						n.shreg = rdat;
						n.drv_low = q.more & ~rdat[7];
						n.st_rd = q.ptr == rtc_ccr_pkg::STATUS_ADDR;
						n.al_snap = {q.al1, q.al0};
					end
				end
				default: n.st = rtc_ccr_pkg::ST_IDLE;
			endcase
		end

		// alarm flags: clear only what was set at read start, new hits win
		if (al_clear) begin
			n.al1 = q.al1 & ~q.al_snap[1];
			n.al0 = q.al0 & ~q.al_snap[0];
		end
		if (i_alarm1_hit) begin
			n.al1 = 1'b1;
		end
		if (i_alarm0_hit) begin
			n.al0 = 1'b1;
		end

		// commit buffered write at valid stop
		if (commit_ok && q.wstat) begin
			case (q.wbuf[7])
				rtc_ccr_pkg::CMD_WL_SET: begin
					n.write_latch_primary = 1'b1;
					n.register_write_latch = 1'b0;
				end
				rtc_ccr_pkg::CMD_BOTH_SET: begin
					n.write_latch_primary = q.write_latch_primary;
					n.register_write_latch = q.write_latch_primary;
				end
				rtc_ccr_pkg::CMD_CLEAR: begin
					n.write_latch_primary = 1'b0;
					n.register_write_latch = 1'b0;
				end
				default: n.write_latch_primary = q.write_latch_primary;
			endcase
		end else if (commit_ok && q.write_latch_primary && q.register_write_latch) begin
			// total supply loss in the same cycle keeps the flag set
			clk_commit = q.wsec == rtc_ccr_pkg::SEC_CLOCK && q.wmask != 8'h0
				&& (q.main_sy[1] | q.bak_sy[1]);
			for (int i = 0; i < 8; i++) begin
				if (q.wmask[i]) begin
					case (q.wsec)
						rtc_ccr_pkg::SEC_CLOCK: begin
							if (i != 7 || q.wbuf[i] == rtc_ccr_pkg::CENT_19
								|| q.wbuf[i] == rtc_ccr_pkg::CENT_20) begin
								n.clk[i] = q.wbuf[i];
							end
						end
						rtc_ccr_pkg::SEC_CTRL: n.nv[16 + i] = q.wbuf[i];
						default: n.nv[{q.wsec[0], 3'(i)}] = q.wbuf[i];
					endcase
				end
			end
			if (clk_commit) begin
				n.total_power_loss_flag = 1'b0;
				n.run = 1'b1;
			end
		end

		if (!i_rstn) begin
			n.st = rtc_ccr_pkg::ST_IDLE;
			n.phase = rtc_ccr_pkg::PH_DEV;
			n.rw = 1'b0;
			n.full = 1'b0;
			n.more = 1'b0;
			n.drv_low = 1'b0;
			n.snap_pend = 1'b0;
			n.bitcnt = 3'h0;
			n.ptr = 6'h0;
			n.wgot = 1'b0;
			n.wstat = 1'b0;
			n.wmask = 8'h0;
			n.clk = rtc_ccr_pkg::CLK_RESET;
			n.nv = '0;
			n.write_latch_primary = 1'b0;
			n.register_write_latch = 1'b0;
			n.al1 = 1'b0;
			n.al0 = 1'b0;
			n.oscillator_stopped_flag = 1'b0;
			n.total_power_loss_flag = rtc_ccr_pkg::SR_RESET[rtc_ccr_pkg::SR_TOTAL_POWER_LOSS_FLAG];
			n.run = 1'b0;
			n.st_rd = 1'b0;
			n.al_snap = 2'b0;
			n.osc_cnt = 16'h0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		q <= n;
	end

	assign o_sda = 1'b0;
	assign o_sda_oe_n = ~q.drv_low;
	assign o_clock_running = q.run;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	property p_reset_latches;
		$rose(i_rstn) |-> !q.write_latch_primary && !q.register_write_latch && q.total_power_loss_flag && !q.run;
	endproperty
	a_reset_latches: assert property (p_reset_latches) else $error("latches or flags wrong after reset");

	property p_stopped_clock;
		sec_tick && !q.run && !commit_ok |=> q.clk == $past(q.clk);
	endproperty
	a_stopped_clock: assert property (p_stopped_clock) else $error("time moved while stopped");

	property p_locked_write;
		commit_ok && !q.wstat && !(q.write_latch_primary && q.register_write_latch) |=> q.nv == $past(q.nv);
	endproperty
	a_locked_write: assert property (p_locked_write) else $error("locked write changed storage");

	property p_clock_write_clears;
		clk_commit |=> !q.total_power_loss_flag && q.run;
	endproperty
	a_clock_write_clears: assert property (p_clock_write_clears) else $error("clock write left power flag");

	property p_alarm_set_wins;
		al_clear && i_alarm0_hit |=> q.al0;
	endproperty
	a_alarm_set_wins: assert property (p_alarm_set_wins) else $error("alarm hit lost during clear");

	property p_backup_flag;
		(i_backup_supply_ok && !i_main_supply_ok) [*4] |=> q.on_backup_supply_flag;
	endproperty
	a_backup_flag: assert property (p_backup_flag) else $error("battery flag not set");

	property p_osc_timeout;
		q.osc_cnt >= OSC_TIMEOUT && !(q.alive_sy[1] ^ q.alive_sy[2]) |=> q.oscillator_stopped_flag;
	endproperty
	a_osc_timeout: assert property (p_osc_timeout) else $error("oscillator flag not set");

	property p_bad_dev_code;
		q.st == rtc_ccr_pkg::ST_RX && q.phase == rtc_ccr_pkg::PH_DEV && q.full && scl_fall
			&& q.shreg[7:1] != rtc_ccr_pkg::DEV_CODE && !bus_stop && !bus_start
			|=> q.st == rtc_ccr_pkg::ST_IDLE ##1 !q.drv_low;
	endproperty
	a_bad_dev_code: assert property (p_bad_dev_code) else $error("foreign slave code answered");

	c_clock_write: cover property (clk_commit);
	c_status_read_clear: cover property (al_clear && q.al_snap != 2'b0);
	c_latch_set: cover property (commit_ok && q.wstat ##1 q.register_write_latch);

endmodule // rtc_clock_control_space

// ==== tb/i2c_master_model.sv ====
// serial bus master model facing the clock/control space
`timescale 1ns/1ps
module i2c_master_model (
	// bus pins seen by the device
	output logic      o_scl,
	output logic      o_sda,
	// device data value and pull-down enable, active low
	input  wire logic i_sda_dout,
	input  wire logic i_sda_oe_n
);
	localparam time Q = 30;
	logic drv_low;

	// open drain line with pull-up
	assign o_sda = !drv_low && (i_sda_oe_n || i_sda_dout);

	initial begin
		o_scl = 1'b1;
		drv_low = 1'b0;
	end

	// start or repeated start; clock idles high between frames
	task automatic bus_start();
		#Q drv_low = 1'b0;
		#Q o_scl = 1'b1;
		#Q drv_low = 1'b1;
		#Q o_scl = 1'b0;
	endtask

	task automatic bus_stop();
		#Q drv_low = 1'b1;
		#Q o_scl = 1'b1;
		#Q drv_low = 1'b0;
		#Q;
	endtask

	// eight data bits and the ninth bit, msb first; line sampled at clock rise
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			#Q drv_low = !tx[i];
			#Q o_scl = 1'b1;
			rx[i] = o_sda;
			#(2*Q) o_scl = 1'b0;
		end
	endtask
endmodule // i2c_master_model

// ==== tb/tb_rtc_clock_control_space.sv ====
// self-checking bench for the clock/control register space
`timescale 1ns/1ps
module tb_rtc_clock_control_space;
	logic       i_ref_clk;
	logic       i_rstn;
	logic       i_xtal_clk;
	logic       xtal_run;
	logic       i_scl;
	logic       i_sda;
	logic       o_sda;
	logic       o_sda_oe_n;
	logic       i_main_supply_ok;
	logic       i_backup_supply_ok;
	logic       i_alarm0_hit;
	logic       i_alarm1_hit;
	logic       o_clock_running;
	logic [8:0] rx;
	logic [7:0] rd_q[$];
	logic [7:0] mdl[$];
	logic [31:0] lfsr = 32'h6ef1093e;
	int         n_fail = 0;
	int         checks_done = 0;
	int         cycles = 0;

	rtc_clock_control_space #(.XTAL_DIV(16'h0400), .OSC_TIMEOUT(16'h0040)) i_rtc_clock_control_space (
		.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_xtal_clk(i_xtal_clk), .i_scl(i_scl), .i_sda(i_sda),
		.o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_main_supply_ok(i_main_supply_ok),
		.i_backup_supply_ok(i_backup_supply_ok), .i_alarm0_hit(i_alarm0_hit), .i_alarm1_hit(i_alarm1_hit),
		.o_clock_running(o_clock_running));
	i2c_master_model i_i2c_master_model (.o_scl(i_scl), .o_sda(i_sda), .i_sda_dout(o_sda),
		.i_sda_oe_n(o_sda_oe_n));

	// ----------------------------------------
	// clocks, watchdog, helpers
	// ----------------------------------------
	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		i_xtal_clk = 1'b0;
		#1.3;
		forever #24 i_xtal_clk = ~i_xtal_clk & xtal_run;
	end
	always @(posedge i_ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_fail++;
			complete_run();
		end
	end
	function automatic logic [7:0] rnd_bcd(input int m);
		int v;
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		v = int'(lfsr % m);
		return 8'((v / 10) * 16 + v % 10);
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (n_fail == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------
	// bus transactions
	// ----------------------------------------
	task automatic head(input logic [7:0] addr);
		i_i2c_master_model.bus_start();
		for (int k = 0; k < 3; k++) begin
			i_i2c_master_model.xfer({k == 0 ? 8'hde : (k == 1 ? 8'h00 : addr), 1'b1}, rx);
			check({7'h00, rx[0]}, 8'h00);
		end
	endtask
	task automatic wr(input logic [7:0] addr, input logic [7:0] d[$]);
		head(addr);
		foreach (d[k]) begin
			i_i2c_master_model.xfer({d[k], 1'b1}, rx);
			check({7'h00, rx[0]}, 8'h00);
		end
		i_i2c_master_model.bus_stop();
	endtask
	task automatic rd(input bit cur, input logic [7:0] addr, input int n);
		rd_q.delete();
		if (!cur) head(addr);
		i_i2c_master_model.bus_start();
		i_i2c_master_model.xfer({8'hdf, 1'b1}, rx);
		for (int k = 0; k < n; k++) begin
			i_i2c_master_model.xfer({8'hff, k == n - 1}, rx);
			rd_q.push_back(rx[8:1]);
		end
		i_i2c_master_model.bus_stop();
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{i_rstn, i_alarm0_hit, i_alarm1_hit} = 3'b000;
		{xtal_run, i_main_supply_ok, i_backup_supply_ok} = 3'b111;
		repeat (10) @(posedge i_ref_clk);
		#1 i_rstn = 1'b1;
		repeat (5) @(posedge i_ref_clk);
		#1;
		i_i2c_master_model.bus_start();
		i_i2c_master_model.xfer({8'hae, 1'b1}, rx);
		i_i2c_master_model.bus_stop();
		check({7'h00, rx[0]}, 8'h01);
		mdl = {8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h20};
		wr(8'h30, '{8'h11});
		rd(0, 8'h30, 8);
		foreach (mdl[k]) check(rd_q[k], mdl[k]);
		rd(0, 8'h20, 1);
		check(rd_q[0], 8'h00);
		wr(8'h3f, '{8'h02});
		wr(8'h3f, '{8'h06});
		rd(0, 8'h3f, 2);
		check(rd_q[0], 8'h07);
		check(rd_q[1], 8'hff);
		mdl = {rnd_bcd(5) & 8'hf0, rnd_bcd(60), 8'h93, 8'h15, 8'h07, rnd_bcd(100), 8'h03, 8'h19};
		wr(8'h30, mdl);
		check({7'h00, o_clock_running}, 8'h01);
		rd(0, 8'h30, 2);
		check(rd_q[1], mdl[1]);
		rd(1, 8'h00, 7);
		for (int k = 0; k < 6; k++) check(rd_q[k], mdl[k + 2]);
		check(rd_q[6] & 8'hf0, mdl[0]);
		for (int k = 0; k < 2; k++) begin
			@(posedge i_ref_clk);
			#1 {i_alarm1_hit, i_alarm0_hit} = 2'b01 << k;
			@(posedge i_ref_clk);
			#1 {i_alarm1_hit, i_alarm0_hit} = 2'b00;
			rd(0, 8'h3f, 1);
			check(rd_q[0], 8'h06 | (8'h20 << k));
			rd(0, 8'h3f, 1);
			check(rd_q[0], 8'h06);
		end
		// match held through a whole status read: the flag must survive its clear
		@(posedge i_ref_clk);
		#1 i_alarm0_hit = 1'b1;
		rd(0, 8'h3f, 1);
		check(rd_q[0], 8'h26);
		@(posedge i_ref_clk);
		#1 {i_main_supply_ok, i_alarm0_hit} = 2'b00;
		rd(0, 8'h3f, 1);
		check(rd_q[0] & 8'ha0, 8'ha0);
		@(posedge i_ref_clk);
		#1 {i_main_supply_ok, xtal_run} = 2'b10;
		repeat (200) @(posedge i_ref_clk);
		#1 rd(0, 8'h3f, 1);
		check(rd_q[0], 8'h16);
		@(posedge i_ref_clk);
		#1 xtal_run = 1'b1;
		repeat (200) @(posedge i_ref_clk);
		#1 rd(0, 8'h3f, 1);
		check(rd_q[0], 8'h06);
		mdl = {8'h59, 8'h59, 8'ha3, 8'h28, 8'h02, 8'h04, 8'h06, 8'h20};
		wr(8'h30, mdl);
		repeat (15000) @(posedge i_ref_clk);
		#1 rd(0, 8'h32, 5);
		mdl = {8'h80, 8'h29, 8'h02, 8'h04, 8'h00};
		foreach (mdl[k]) check(rd_q[k], mdl[k]);
		complete_run();
	end
endmodule // tb_rtc_clock_control_space
